// ===== gear_clock_pkg.sv
// Constants, register map and gear-ratio decode for the gear-ratio clock output control block.
package gear_clock_pkg;

  // ==========================================================================
  // Register offsets on the serial configuration port
  // ==========================================================================
  localparam logic [7:0] REG_GEAR = 8'h00;
  localparam logic [7:0] REG_OUT_LOW = 8'h01;
  localparam logic [7:0] REG_OUT_HIGH = 8'h02;
  localparam logic [7:0] REG_READBACK_LOW = 8'h03;
  localparam logic [7:0] REG_READBACK_HIGH = 8'h04;
  localparam logic [7:0] REG_BYTE_COUNT = 8'h07;
  localparam logic [7:0] REG_FREQ_SELECT = 8'h08;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int GEAR_WIDE_ONE_TO_ONE_BIT = 7;
  localparam int GEAR_NARROW_ONE_TO_ONE_BIT = 6;
  localparam int GEAR_BAND_BIT = 4;
  localparam int OUT_HIGH_BANDWIDTH_BIT = 6;
  localparam int OUT_HIGH_PLL_BIT = 5;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] GEAR_RESET = 8'hE9;
  localparam logic [7:0] OUT_LOW_RESET = 8'hFF;
  localparam logic [7:0] OUT_HIGH_RESET = 8'hFF;
  localparam logic [7:0] BYTE_COUNT_RESET = 8'h09;
  localparam logic [2:0] FREQ_BAND_HIGH_DEFAULT = 3'h3;
  localparam logic [2:0] FREQ_BAND_LOW_DEFAULT = 3'h6;
  localparam logic [2:0] FREQ_RESET = 3'h6;
  localparam logic [3:0] GEAR_CODE_UNITY = 4'h9;
  localparam logic [7:0] RATIO_UNITY = 8'h11;

  // ==========================================================================
  // Serial port
  // ==========================================================================
  localparam logic [3:0] SLAVE_ADDR_BASE = 4'hD;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] FIRST_DATA_BYTE = 2'h3;

  typedef enum {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_HOST_ACK} serial_state_type;

  // Returns {m, n}; output frequency is input times n/m.
  function automatic logic [7:0] gearRatio(input logic [4:0] code);
    logic [7:0] r;
    r = RATIO_UNITY;
    unique case (code[3:0])
      4'h0: r = 8'h31;
      4'h1: r = 8'h52;
      4'h2: r = 8'hC5;
      4'h3: r = 8'h21;
      4'h4: r = 8'h53;
      4'h5: r = 8'h85;
      4'h6: r = 8'h32;
      4'h7: r = code[4] ? 8'h54 : 8'h43;
      4'h8: r = 8'h65;
      4'h9: r = 8'h11;
      4'hA: r = 8'h56;
      4'hB: r = 8'h45;
      4'hC: r = 8'h34;
      4'hD: r = 8'h23;
      4'hE: r = 8'h35;
      4'hF: r = 8'h12;
    endcase
    return r;
  endfunction

endpackage

// ===== gear_ratio_clock_output_control.sv
// Configuration, strap latching and output control of the twelve-pair gear-ratio clock buffer.
//
// How it works
// - Pair drives only while its enable pin low.
// - One shared enable gates pairs ten and eleven.
// - Bypass strap low fanout, high zero-delay.
// - Three straps form low slave address bits.
// - Power-down pin stops clocks asynchronously.
// - All outputs start in 1:1 mode.
// - Two output groups configured independently.
// - Five-bit gear code selects m and n.
// - Gear bits power up to 1001.
// - Band strap selects input frequency band.
// - Three-bit code sets expected input frequency.
// - Band strap high defaults code to 011.
// - Two-wire slave port for configuration access.
// - Per-group gear enable, 1 means 1:1.
`timescale 1ns/10ps
`default_nettype none

module gear_ratio_clock_output_control #(
  parameter int PAIR_COUNT = 12
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic [9:0] pairEnableLow,
  input wire logic sharedPairEnableLow,
  input wire logic loopBandwidthSelect,
  input wire logic slaveAddrStrapLsb,
  input wire logic slaveAddrStrapMid,
  input wire logic addrStrapBypassSelect,
  input wire logic powerGoodPowerdown,
  input wire logic freqBandStrap,
  input wire logic serialClockLine,
  input wire logic serialDataLineIn,
  input wire logic wideGroupClkLow,
  input wire logic narrowGroupClkLow,
  output logic serialDataLineOut,
  output logic serialDataLineOe,
  output logic [11:0] pairDriveEnable,
  output logic [3:0] wideM,
  output logic [3:0] wideN,
  output logic [3:0] narrowM,
  output logic [3:0] narrowN,
  output logic zeroDelayMode,
  output logic pllLowBandwidth,
  output logic freqCodeHigh,
  output logic freqCodeMid,
  output logic freqBand,
  output logic clocksStopped
);

  initial begin
    if (PAIR_COUNT != 12) $error("Only twelve output pairs are supported.");
  end

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [20:0] rawIn;
  logic [20:0] syncMeta;
  logic [20:0] syncIn;
  logic sclS, sdaS, pgS, bandS, bwS, bypS, sharedS, wideLowS, narrowLowS;
  logic [1:0] addrLowS;
  logic [9:0] oeLowS;
  logic sclPrev, sdaPrev;

  assign rawIn = {serialClockLine, serialDataLineIn, powerGoodPowerdown, freqBandStrap,
                  loopBandwidthSelect, addrStrapBypassSelect, slaveAddrStrapMid,
                  slaveAddrStrapLsb, sharedPairEnableLow, pairEnableLow,
                  wideGroupClkLow, narrowGroupClkLow};
  assign {sclS, sdaS, pgS, bandS, bwS, bypS, addrLowS, sharedS, oeLowS,
          wideLowS, narrowLowS} = syncIn;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      // Idle levels: a zero here would read as power-good and latch straps at reset.
      syncMeta <= '1;
      syncIn <= '1;
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else if (clkEn) begin
      syncMeta <= rawIn;
      syncIn <= syncMeta;
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  wire sclRise = sclS && !sclPrev;
  wire sclFall = !sclS && sclPrev;
  wire startCond = sclS && sclPrev && sdaPrev && !sdaS;
  wire stopCond = sclS && sclPrev && !sdaPrev && sdaS;

  // The pin carries both meanings: low is power-good, a later high is power-down.
  // Stopping must not wait for a clock that is itself being stopped.
  assign clocksStopped = powerGoodPowerdown;
  assign serialDataLineOut = 1'b0;

  // ==========================================================================
  // Strap latch and register file
  // ==========================================================================
  gear_clock_pkg::serial_state_type state;
  logic pgLatched, bypassStrap;
  logic [2:0] addrStrap;
  logic [7:0] gearReg, outLowReg, outHighReg, countReg, ptr, rxShift, txShift;
  logic [2:0] freqReg;
  logic [3:0] bitCnt;
  logic [1:0] byteNum;
  logic isRead, countPending;

  wire latchNow = !pgLatched && !pgS;
  wire [6:0] ownAddr = {gear_clock_pkg::SLAVE_ADDR_BASE, addrStrap};
  wire addrMatch = pgLatched && (rxShift[7:1] == ownAddr);
  wire byteDone = (state == gear_clock_pkg::ST_RECV) && sclFall
                  && (bitCnt == gear_clock_pkg::BITS_PER_BYTE);
  wire ackThis = (byteNum != 2'h0) || addrMatch;
  wire writeNow = byteDone && (byteNum == gear_clock_pkg::FIRST_DATA_BYTE);
  wire [7:0] readData =
    (ptr == gear_clock_pkg::REG_GEAR) ? gearReg :
    (ptr == gear_clock_pkg::REG_OUT_LOW) ? outLowReg :
    (ptr == gear_clock_pkg::REG_OUT_HIGH) ? outHighReg :
    (ptr == gear_clock_pkg::REG_READBACK_LOW) ? oeLowS[7:0] :
    (ptr == gear_clock_pkg::REG_READBACK_HIGH) ?
      {bandS, bwS, bypS, 2'h0, sharedS, oeLowS[9:8]} :
    (ptr == gear_clock_pkg::REG_BYTE_COUNT) ? countReg :
    (ptr == gear_clock_pkg::REG_FREQ_SELECT) ? {5'h00, freqReg} : 8'h00;
  wire [7:0] nextTx = countPending ? countReg : readData;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pgLatched <= 1'b0;
      addrStrap <= '0;
      bypassStrap <= 1'b0;
      gearReg <= gear_clock_pkg::GEAR_RESET;
      outLowReg <= gear_clock_pkg::OUT_LOW_RESET;
      outHighReg <= gear_clock_pkg::OUT_HIGH_RESET;
      countReg <= gear_clock_pkg::BYTE_COUNT_RESET;
      freqReg <= gear_clock_pkg::FREQ_RESET;
    end else if (clkEn) begin
      if (latchNow) begin
        pgLatched <= 1'b1;
        addrStrap <= {bypS, addrLowS};
        bypassStrap <= bypS;
        gearReg[gear_clock_pkg::GEAR_BAND_BIT] <= bandS;
        freqReg <= bandS ? gear_clock_pkg::FREQ_BAND_HIGH_DEFAULT
                         : gear_clock_pkg::FREQ_BAND_LOW_DEFAULT;
      end else if (writeNow) begin
        unique case (ptr)
          gear_clock_pkg::REG_GEAR: gearReg <= rxShift;
          gear_clock_pkg::REG_OUT_LOW: outLowReg <= rxShift;
          gear_clock_pkg::REG_OUT_HIGH: outHighReg <= rxShift;
          gear_clock_pkg::REG_BYTE_COUNT: countReg <= rxShift;
          gear_clock_pkg::REG_FREQ_SELECT: freqReg <= rxShift[2:0];
          default: ;
        endcase
      end
    end
  end

  // ==========================================================================
  // Two-wire slave: index block write and index block read
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= gear_clock_pkg::ST_IDLE;
      serialDataLineOe <= 1'b0;
      bitCnt <= '0;
      byteNum <= '0;
      ptr <= '0;
      rxShift <= '0;
      txShift <= '0;
      isRead <= 1'b0;
      countPending <= 1'b0;
    end else if (clkEn) begin
      if (startCond) begin
        state <= gear_clock_pkg::ST_RECV;
        serialDataLineOe <= 1'b0;
        bitCnt <= '0;
        byteNum <= '0;
      end else if (stopCond) begin
        state <= gear_clock_pkg::ST_IDLE;
        serialDataLineOe <= 1'b0;
      end else begin
        unique case (state)
          gear_clock_pkg::ST_IDLE: ;
          gear_clock_pkg::ST_RECV: begin
            if (sclRise) begin
              rxShift <= {rxShift[6:0], sdaS};
              bitCnt <= bitCnt + 4'h1;
            end else if (byteDone) begin
              bitCnt <= '0;
              serialDataLineOe <= ackThis;
              state <= ackThis ? gear_clock_pkg::ST_ACK : gear_clock_pkg::ST_IDLE;
              if (byteNum != gear_clock_pkg::FIRST_DATA_BYTE) byteNum <= byteNum + 2'h1;
              if (byteNum == 2'h0) begin
                isRead <= rxShift[0];
                countPending <= rxShift[0];
              end
              if (byteNum == 2'h1) ptr <= rxShift;
              if (writeNow) ptr <= ptr + 8'h01;
            end
          end
          gear_clock_pkg::ST_ACK: begin
            if (sclFall) begin
              bitCnt <= '0;
              if (isRead) begin
                // The byte count goes out first, then the bytes from the pointer on.
                txShift <= nextTx;
                serialDataLineOe <= !nextTx[7];
                countPending <= 1'b0;
                if (!countPending) ptr <= ptr + 8'h01;
                state <= gear_clock_pkg::ST_SEND;
              end else begin
                serialDataLineOe <= 1'b0;
                state <= gear_clock_pkg::ST_RECV;
              end
            end
          end
          gear_clock_pkg::ST_SEND: begin
            if (sclRise) begin
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall) begin
              if (bitCnt == gear_clock_pkg::BITS_PER_BYTE) begin
                serialDataLineOe <= 1'b0;
                state <= gear_clock_pkg::ST_HOST_ACK;
              end else begin
                serialDataLineOe <= !txShift[6];
                txShift <= {txShift[6:0], 1'b0};
              end
            end
          end
          gear_clock_pkg::ST_HOST_ACK: begin
            if (sclRise) state <= sdaS ? gear_clock_pkg::ST_IDLE : gear_clock_pkg::ST_ACK;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Output application, glitch-free per group
  // ==========================================================================
  // Enables and ratios move only while the group's clock is low, so no runt pulse can leave the pin.
  wire [9:0] wideEnable = ~oeLowS & {outHighReg[1:0], outLowReg};
  wire [1:0] narrowEnable = {2{~sharedS}} & outHighReg[3:2];
  wire [4:0] gearCode = {gearReg[gear_clock_pkg::GEAR_BAND_BIT], gearReg[3:0]};
  wire [7:0] wideRatio = gearReg[gear_clock_pkg::GEAR_WIDE_ONE_TO_ONE_BIT]
    ? gear_clock_pkg::RATIO_UNITY : gear_clock_pkg::gearRatio(gearCode);
  wire [7:0] narrowRatio = gearReg[gear_clock_pkg::GEAR_NARROW_ONE_TO_ONE_BIT]
    ? gear_clock_pkg::RATIO_UNITY : gear_clock_pkg::gearRatio(gearCode);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pairDriveEnable <= '0;
      wideM <= 4'h1;
      wideN <= 4'h1;
      narrowM <= 4'h1;
      narrowN <= 4'h1;
      zeroDelayMode <= 1'b0;
      pllLowBandwidth <= 1'b0;
      freqCodeHigh <= 1'b0;
      freqCodeMid <= 1'b0;
      freqBand <= 1'b0;
    end else if (clkEn) begin
      if (wideLowS) begin
        pairDriveEnable[9:0] <= wideEnable;
        {wideM, wideN} <= wideRatio;
      end
      if (narrowLowS) begin
        pairDriveEnable[11:10] <= narrowEnable;
        {narrowM, narrowN} <= narrowRatio;
      end
      zeroDelayMode <= bypassStrap && outHighReg[gear_clock_pkg::OUT_HIGH_PLL_BIT];
      pllLowBandwidth <= bwS && outHighReg[gear_clock_pkg::OUT_HIGH_BANDWIDTH_BIT];
      {freqCodeHigh, freqCodeMid, freqBand} <= freqReg;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_wideOff;
    clkEn && wideLowS && oeLowS[0];
  endsequence

  property p_pairOff;
    s_wideOff |=> !pairDriveEnable[0];
  endproperty
  a_pairOff: assert property (p_pairOff) else $error("Pair 0 driven while disabled.");

  property p_sharedOff;
    clkEn && narrowLowS && sharedS |=> pairDriveEnable[11:10] == 2'h0;
  endproperty
  a_sharedOff: assert property (p_sharedOff) else $error("Pairs 10/11 driven.");

  property p_bypass;
    zeroDelayMode |-> bypassStrap && pgLatched;
  endproperty
  a_bypass: assert property (p_bypass) else $error("Zero-delay mode with strap low.");

  property p_addrAck;
    byteDone && byteNum == 2'h0 && clkEn |=> serialDataLineOe == addrMatch;
  endproperty
  a_addrAck: assert property (p_addrAck) else $error("Address acknowledge wrong.");

  property p_bandwidth;
    clkEn && !bwS |=> !pllLowBandwidth;
  endproperty
  a_bandwidth: assert property (p_bandwidth) else $error("Low bandwidth with pin at 0.");

  property p_strapStable;
    pgLatched |=> $stable(addrStrap) && $stable(bypassStrap);
  endproperty
  a_strapStable: assert property (p_strapStable) else $error("Strap moved after latch.");

  property p_gearDefault;
    !pgLatched |-> gearReg[3:0] == gear_clock_pkg::GEAR_CODE_UNITY;
  endproperty
  a_gearDefault: assert property (p_gearDefault) else $error("Gear bits not 1001.");

  property p_bandDefault;
    latchNow && clkEn && bandS |=> freqReg == gear_clock_pkg::FREQ_BAND_HIGH_DEFAULT;
  endproperty
  a_bandDefault: assert property (p_bandDefault) else $error("Band default not 011.");

  property p_unity;
    clkEn && wideLowS && gearReg[gear_clock_pkg::GEAR_WIDE_ONE_TO_ONE_BIT]
      |=> wideM == 4'h1 && wideN == 4'h1;
  endproperty
  a_unity: assert property (p_unity) else $error("Wide group not 1:1.");

  property p_lowBoundary;
    $changed(pairDriveEnable[9:0]) |-> $past(wideLowS);
  endproperty
  a_lowBoundary: assert property (p_lowBoundary) else $error("Enable moved while high.");

endmodule // gear_ratio_clock_output_control

`default_nettype wire

// ===== gear_ratio_clock_output_control_tb.sv
// Self-checking testbench of the gear-ratio clock output control block.
`timescale 1ns/10ps
`default_nettype none

module gear_ratio_clock_output_control_tb;
  typedef struct packed {
    logic [9:0] pins;
    logic shared;
    logic bw;
    logic [11:0] drive;
    logic lowBw;
  } row_type;
  localparam row_type ROWS [4] = '{'{10'h000, 1'b0, 1'b0, 12'hFFF, 1'b0},
    '{10'h3FF, 1'b1, 1'b1, 12'h000, 1'b1}, '{10'h155, 1'b0, 1'b0, 12'hEAA, 1'b0},
    '{10'h2AA, 1'b1, 1'b1, 12'h155, 1'b1}};
  // Packed {m, n} per gear code; code 7 holds the band-one entry.
  localparam logic [7:0] RATIO [16] = '{8'h31, 8'h52, 8'hC5, 8'h21, 8'h53, 8'h85, 8'h32,
    8'h54, 8'h65, 8'h11, 8'h56, 8'h45, 8'h34, 8'h23, 8'h35, 8'h12};
  localparam logic [2:0] FREQ_CODES [7] = '{3'h5, 3'h1, 3'h3, 3'h2, 3'h0, 3'h4, 3'h6};
  localparam int CYCLE_LIMIT = 60000;

  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [9:0] pairEnableLow = 10'h000;
  logic sharedPairEnableLow = 1'b0;
  logic loopBandwidthSelect = 1'b0;
  logic slaveAddrStrapLsb = 1'b1;
  logic slaveAddrStrapMid = 1'b0;
  logic addrStrapBypassSelect = 1'b1;
  logic powerGoodPowerdown = 1'b1;
  logic freqBandStrap = 1'b1;
  logic wideGroupClkLow = 1'b1;
  logic narrowGroupClkLow = 1'b1;
  logic serialClockLine, serialDataLine, serialDataLineOut, serialDataLineOe;
  logic [11:0] pairDriveEnable;
  logic [3:0] wideM, wideN, narrowM, narrowN;
  logic zeroDelayMode, pllLowBandwidth, freqCodeHigh, freqCodeMid, freqBand, clocksStopped;
  logic nack;
  logic [7:0] cnt, dat;
  int err_count = 0;
  int check_count = 0;
  int cycleCount = 0;
  wire [15:0] ratios = {wideM, wideN, narrowM, narrowN};
  wire [3:0] modes = {zeroDelayMode, freqCodeHigh, freqCodeMid, freqBand};

  gear_ratio_clock_output_control #(.PAIR_COUNT(12)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(1'b1), .pairEnableLow(pairEnableLow),
    .sharedPairEnableLow(sharedPairEnableLow), .loopBandwidthSelect(loopBandwidthSelect),
    .slaveAddrStrapLsb(slaveAddrStrapLsb), .slaveAddrStrapMid(slaveAddrStrapMid),
    .addrStrapBypassSelect(addrStrapBypassSelect), .powerGoodPowerdown(powerGoodPowerdown),
    .freqBandStrap(freqBandStrap), .serialClockLine(serialClockLine),
    .serialDataLineIn(serialDataLine), .wideGroupClkLow(wideGroupClkLow),
    .narrowGroupClkLow(narrowGroupClkLow), .serialDataLineOut(serialDataLineOut),
    .serialDataLineOe(serialDataLineOe), .pairDriveEnable(pairDriveEnable), .wideM(wideM),
    .wideN(wideN), .narrowM(narrowM), .narrowN(narrowN), .zeroDelayMode(zeroDelayMode),
    .pllLowBandwidth(pllLowBandwidth), .freqCodeHigh(freqCodeHigh),
    .freqCodeMid(freqCodeMid), .freqBand(freqBand), .clocksStopped(clocksStopped));

  serial_host_model u_host (
    .sysClk(sys_clk), .devPullLow(serialDataLineOe), .scl(serialClockLine),
    .sda(serialDataLine));

  always #25 sys_clk = ~sys_clk;

  // ==========================================================================
  // Checking and closing
  // ==========================================================================
  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic checkVal(input logic [15:0] got, input logic [15:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Outputs follow pins and the clock-low indicators three edges late.
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic gearCase(input logic [7:0] value, input logic [15:0] exp);
    u_host.writeReg(7'h6D, 8'h00, value, nack);
    checkVal(ratios, exp);
  endtask

  always @(posedge sys_clk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == CYCLE_LIMIT) begin
      err_count = err_count + 1;
      conclude();
    end
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    settle();
    checkVal({4'h0, pairDriveEnable}, 16'h0FFF);
    checkVal({15'h0, serialDataLineOut}, 16'h0000);
    checkVal(ratios, 16'h1111);
    checkVal({12'h0, modes}, 16'h0006);
    // The straps were set at time zero and stay put through the latch.
    powerGoodPowerdown = 1'b0;
    settle();
    checkVal({12'h0, modes}, 16'h000B);
    checkVal(ratios, 16'h1111);
    checkVal({15'h0, clocksStopped}, 16'h0000);
    foreach (ROWS[i]) begin
      pairEnableLow = ROWS[i].pins;
      sharedPairEnableLow = ROWS[i].shared;
      loopBandwidthSelect = ROWS[i].bw;
      settle();
      checkVal({4'h0, pairDriveEnable}, {4'h0, ROWS[i].drive});
      checkVal({15'h0, pllLowBandwidth}, {15'h0, ROWS[i].lowBw});
    end
    pairEnableLow = 10'h000;
    sharedPairEnableLow = 1'b0;
    u_host.readReg(7'h6D, 8'h08, cnt, dat);
    checkVal({cnt, dat}, 16'h0903);
    // Band-one codes only, so no entry outside the ratio table is programmed.
    for (int c = 0; c < 16; c++) begin
      gearCase({4'h1, c[3:0]}, {RATIO[c], RATIO[c]});
    end
    gearCase(8'h07, 16'h4343);
    gearCase(8'h90, 16'h1131);
    gearCase(8'h50, 16'h3111);
    wideGroupClkLow = 1'b0;
    gearCase(8'h1F, 16'h3112);
    wideGroupClkLow = 1'b1;
    settle();
    checkVal(ratios, 16'h1212);
    u_host.writeReg(7'h68, 8'h00, 8'h10, nack);
    checkVal({15'h0, nack}, 16'h0001);
    checkVal(ratios, 16'h1212);
    foreach (FREQ_CODES[k]) begin
      u_host.writeReg(7'h6D, 8'h08, {5'h0, FREQ_CODES[k]}, nack);
      checkVal({13'h0, freqCodeHigh, freqCodeMid, freqBand}, {13'h0, FREQ_CODES[k]});
    end
    slaveAddrStrapLsb = 1'b0;
    addrStrapBypassSelect = 1'b0;
    freqBandStrap = 1'b0;
    powerGoodPowerdown = 1'b1;
    sys_rst = 1'b1;
    settle();
    sys_rst = 1'b0;
    powerGoodPowerdown = 1'b0;
    settle();
    checkVal({12'h0, modes}, 16'h0006);
    u_host.writeReg(7'h68, 8'h01, 8'h00, nack);
    checkVal({15'h0, nack}, 16'h0000);
    settle();
    checkVal({4'h0, pairDriveEnable}, 16'h0F00);
    powerGoodPowerdown = 1'b1;
    #1 checkVal({15'h0, clocksStopped}, 16'h0001);
    conclude();
  end
endmodule // gear_ratio_clock_output_control_tb
`default_nettype wire

// ===== serial_host_model.sv
// Two-wire host model: drives the serial clock and shares the pulled-up data line.
`timescale 1ns/10ps
`default_nettype none

module serial_host_model (
  input wire logic sysClk,
  input wire logic devPullLow,
  output logic scl,
  output logic sda
);
  logic hostLow = 1'b0;
  initial scl = 1'b1;
  // A released line reads high through the pull-up, never the last driven value.
  assign sda = !(hostLow || devPullLow);

  // Each phase lasts 8 cycles, well above the 3-cycle minimum of the port.
  task automatic wait8();
    repeat (8) @(negedge sysClk);
  endtask

  task automatic startBit();
    repeat (2) @(negedge sysClk);
    hostLow = 1'b0;
    wait8();
    scl = 1'b1;
    wait8();
    hostLow = 1'b1;
    wait8();
    scl = 1'b0;
  endtask

  task automatic stopBit();
    repeat (2) @(negedge sysClk);
    hostLow = 1'b1;
    wait8();
    scl = 1'b1;
    wait8();
    hostLow = 1'b0;
    wait8();
  endtask

  // Nine bits MSB first; a 1 releases the line so the device may answer.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      repeat (2) @(negedge sysClk);
      hostLow = !tx[i];
      wait8();
      scl = 1'b1;
      wait8();
      rx[i] = sda;
      scl = 1'b0;
    end
  endtask

  task automatic writeReg(input logic [6:0] addr, input logic [7:0] idx,
                          input logic [7:0] data, output logic nack);
    logic [8:0] r;
    startBit();
    xfer({addr, 2'b01}, r);
    nack = r[0];
    xfer({idx, 1'b1}, r);
    xfer({8'h01, 1'b1}, r);
    xfer({data, 1'b1}, r);
    stopBit();
  endtask

  // The host acknowledges the count byte and refuses the data byte to end the read.
  task automatic readReg(input logic [6:0] addr, input logic [7:0] idx,
                         output logic [7:0] count, output logic [7:0] data);
    logic [8:0] r;
    startBit();
    xfer({addr, 2'b01}, r);
    xfer({idx, 1'b1}, r);
    startBit();
    xfer({addr, 2'b11}, r);
    xfer(9'h1FE, r);
    count = r[8:1];
    xfer(9'h1FF, r);
    data = r[8:1];
    stopBit();
  endtask
endmodule // serial_host_model
`default_nettype wire
